// File: hdl/acs_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acs_fifo
  import acs_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // streams
  acs_stream_if.dst wr,
  acs_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      next_count;
  logic             do_wr;
  logic             do_rd;
  logic [WIDTH-1:0] rdata;

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = rdata;

  always_comb
  begin
    do_wr      = wr.valid && wr.ready;
    do_rd      = rd.valid && rd.ready;
    next_wptr  = do_wr ? wptr + 1'b1 : wptr;
    next_rptr  = do_rd ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem[wptr] <= wr.data;
  end

  assign rdata = mem[rptr];
endmodule : acs_fifo
`default_nettype wire

// File: hdl/acs_top.sv
// conversion control, auto-sleep and serial readout of a 14-bit converter
// Functional notes
// - start falling edge begins conversion, busy high throughout
// - start still low when busy falls enters sleep
// - start rising edge wakes device, one-shot times 5 us
// - pulse over 6 us: sample at fall, done 5 us later
// - stored result still readable while asleep, sixteen clocks
// - data changes after each falling clock edge, valid both edges
// - first leading zero driven on first rising edge
// - frame is two zeros then 14-bit result, msb first
// - lsb held through 16th falling edge, then output released
// - extra clocks restart shifting, output driven again from next rising edge
// - counter and shifter reset at start fall if clock low
// - conversion end drops busy and queues result, loaded into output register only between reads
// - non-continuous serial clock accepted
// - device is slave and never drives the serial clock
// - result code is supplied already encoded by converter core
`timescale 1ns/1ps
`default_nettype none
module acs_top
  import acs_pkg::*;
#(
  parameter int W          = RESULT_W,
  parameter int WAKE_COUNT = WAKE_CYC,
  parameter int CONV_COUNT = CONV_CYC
)(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // pins from host
  input  wire logic         i_conversion_start_n,
  input  wire logic         i_sclk,
  // pins to host
  output logic              o_busy,
  output logic              o_serial_result_out,
  output logic              o_serial_result_oe,
  // converter core result source
  input  wire logic [W-1:0] i_core_code,
  // status
  output logic              o_asleep
);
  // two-flop synchronisers for pins
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic ck_m;
  logic ck_s;
  logic ck_d;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_d <= 1'b0;
    end
    else
    begin
      cs_m <= i_conversion_start_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      ck_m <= i_sclk;
      ck_s <= ck_m;
      ck_d <= ck_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic ck_rise;
  logic ck_fall;

  // edge of a synchronised level from its last two samples
  function automatic logic fell_of(input logic prev, input logic cur);
    fell_of = prev && !cur;
  endfunction : fell_of

  function automatic logic rose_of(input logic prev, input logic cur);
    rose_of = !prev && cur;
  endfunction : rose_of

  assign cs_fall = fell_of(cs_d, cs_s);
  assign cs_rise = rose_of(cs_d, cs_s);
  assign ck_rise = rose_of(ck_d, ck_s);
  assign ck_fall = fell_of(ck_d, ck_s);

  // conversion state machine
  acs_state_type          state;
  acs_state_type          next_state;
  logic [TMR_W-1:0]       tmr;
  logic [TMR_W-1:0]       next_tmr;
  logic                   conv_done;
  logic                   woke;
  logic                   next_woke;

  // both timers run out on their last count
  function automatic logic timer_last(input logic [TMR_W-1:0] t);
    timer_last = (t == TMR_ONE);
  endfunction : timer_last

  // conversion timer start value
  function automatic logic [TMR_W-1:0] conv_load();
    conv_load = TMR_W'(CONV_COUNT);
  endfunction : conv_load

  always_comb
  begin
    next_state = state;
    next_tmr   = (tmr != TMR_ZERO) ? tmr - TMR_ONE : TMR_ZERO;
    next_woke  = woke;
    conv_done  = 1'b0;
    case (state)
      ACS_IDLE:
      begin
        if (cs_fall)
        begin
          next_state = ACS_CONV;
          next_tmr   = conv_load();
        end
      end
      ACS_CONV:
      begin
        if (timer_last(tmr))
        begin
          conv_done = 1'b1;
          next_state = cs_s ? ACS_IDLE : ACS_SLEEP;
        end
      end
      ACS_SLEEP:
      begin
        if (cs_rise)
        begin
          next_state = ACS_WAKE;
          next_tmr   = TMR_W'(WAKE_COUNT);
          next_woke  = 1'b0;
        end
      end
      ACS_WAKE:
      begin
        if (timer_last(tmr))
          next_woke = 1'b1;
        // long pulse: sample on fall, done 5 us after it
        if (cs_fall && woke)
        begin
          next_state = ACS_CONV;
          next_tmr   = conv_load();
        end
        // short pulse: conversion follows wake-up interval
        else if (!cs_s && timer_last(tmr))
        begin
          next_state = ACS_CONV;
          next_tmr   = conv_load();
        end
      end
      default:
      begin
        next_state = ACS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= ACS_IDLE;
      tmr   <= TMR_ZERO;
      woke  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr   <= next_tmr;
      woke  <= next_woke;
    end
  end

  assign o_busy   = (state == ACS_CONV);
  assign o_asleep = (state == ACS_SLEEP);

  // results pass through the fifo into the output register
  // the queue drains between reads, so only a long stalled read can fill it
  acs_stream_if #(.WIDTH(W)) res_in ();
  acs_stream_if #(.WIDTH(W)) res_out ();

  assign res_in.valid = conv_done;
  assign res_in.data  = i_core_code;

  acs_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .wr        (res_in),
    .rd        (res_out)
  );

  // serial shifter: count of edges, frame register, output
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      next_cnt;
  logic [W-1:0]          out_reg;
  logic [W-1:0]          next_out_reg;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic                  sdo;
  logic                  next_sdo;
  logic                  oe;
  logic                  next_oe;
  logic                  take;

  function automatic logic [FRAME_BITS-1:0] frame_of(input logic [W-1:0] code);
    frame_of = {{LEAD_ZEROS{1'b0}}, code};
  endfunction : frame_of

  // fifo drains only while no read is in progress
  assign take          = res_out.valid && (cnt == CNT_ZERO);
  assign res_out.ready = take;

  always_comb
  begin
    next_cnt     = cnt;
    next_out_reg = take ? res_out.data : out_reg;
    next_shreg   = shreg;
    next_sdo     = sdo;
    next_oe      = oe;
    // reset at start fall only with clock low
    if (cs_fall && !ck_s)
    begin
      next_cnt   = CNT_ZERO;
      next_shreg = frame_of(next_out_reg);
      next_oe    = 1'b0;
      next_sdo   = 1'b0;
    end
    // first zero driven on first rising edge
    else if (ck_rise && (cnt == CNT_ZERO))
    begin
      // readable in any state including sleep
      next_shreg = frame_of(next_out_reg);
      next_sdo   = 1'b0;
      next_oe    = 1'b1;
      next_cnt   = CNT_ONE;
    end
    // change after falling edge, any clock gaps
    else if (ck_fall && (cnt != CNT_ZERO))
    begin
      if (cnt == CNT_LAST)
      begin
        // release after 16th falling edge, extra clocks restart
        next_oe  = 1'b0;
        next_cnt = CNT_ZERO;
      end
      else
      begin
        next_shreg = {shreg[FRAME_BITS-2:0], 1'b0};
        next_sdo   = shreg[FRAME_BITS-2];
        next_cnt   = cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt     <= CNT_ZERO;
      out_reg <= '0;
      shreg   <= '0;
      sdo     <= 1'b0;
      oe      <= 1'b0;
    end
    else
    begin
      cnt     <= next_cnt;
      out_reg <= next_out_reg;
      shreg   <= next_shreg;
      sdo     <= next_sdo;
      oe      <= next_oe;
    end
  end

  assign o_serial_result_out = sdo;
  assign o_serial_result_oe  = oe;
endmodule : acs_top
`default_nettype wire

// File: inc/acs_pkg.sv
// shared constants for the converter sleep and serial readout block
package acs_pkg;
  localparam int          RESULT_W       = 14;
  localparam int          FRAME_BITS     = 16;
  localparam int          LEAD_ZEROS     = 2;
  localparam int          CNT_W          = 5;
  localparam int          CLK_MHZ        = 250;
  localparam int          WAKE_NS        = 5000;
  localparam int          CONV_NS        = 5000;
  localparam int          WAKE_CYC       = (WAKE_NS * CLK_MHZ) / 1000;
  localparam int          CONV_CYC       = (CONV_NS * CLK_MHZ) / 1000;
  localparam int          TMR_W          = 16;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;
  localparam logic [4:0]  CNT_ONE        = 5'h01;
  localparam logic [4:0]  CNT_LAST       = 5'h10;
  localparam logic [15:0] TMR_ZERO       = 16'h0000;
  localparam logic [15:0] TMR_ONE        = 16'h0001;

  typedef enum logic [3:0] {
    ACS_IDLE  = 4'b0001,
    ACS_CONV  = 4'b0010,
    ACS_SLEEP = 4'b0100,
    ACS_WAKE  = 4'b1000
  } acs_state_type;
endpackage : acs_pkg

// File: inc/acs_stream_if.sv
// valid/ready word stream between block modules
`timescale 1ns/1ps
`default_nettype none
interface acs_stream_if #(parameter int WIDTH = 14);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : acs_stream_if
`default_nettype wire

// File: tb/acs_host_model.sv
// host side: start pin and serial clock master
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  // pins to block
  output var logic o_conversion_start_n,
  output var logic o_sclk,
  // pins from block
  input  wire logic i_busy,
  input  wire logic i_sdo_line
);
  logic sel;
  initial
  begin
    o_conversion_start_n = 1'b1;
    o_sclk = 1'b0;
    sel = 1'b1;
  end
  // select line gates the clock to the block
  task automatic set_select(input logic on);
    sel = on;
  endtask : set_select
  // 8 MHz clock, low between bytes
  task automatic read_bits(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      if (k == 8)
        #400;
      o_sclk = sel;
      #62.5;
      bits = {bits[14:0], i_sdo_line};
      o_sclk = 1'b0;
      #62.5;
    end
    #300;
  endtask : read_bits
  // start moves only with clock low
  task automatic set_start(input logic lvl, input int hold_ns);
    o_conversion_start_n = lvl;
    #(hold_ns);
  endtask : set_start
  task automatic wait_busy(input logic lvl, output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 4000 && !ok; k++)
      #4 ok = (i_busy === lvl);
  endtask : wait_busy
endmodule : acs_host_model
`default_nettype wire

// File: tb/acs_top_monitor.sv
// pin-level checker for the conversion and readout block
`timescale 1ns/1ps
`default_nettype none
module acs_top_monitor #(
  parameter int W          = 14,
  parameter int CONV_COUNT = 20
)(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // watched pins
  input  wire logic         i_conversion_start_n,
  input  wire logic         i_sclk,
  input  wire logic         o_busy,
  input  wire logic         o_serial_result_out,
  input  wire logic         o_serial_result_oe,
  input  wire logic [W-1:0] i_core_code,
  input  wire logic         o_asleep
);
  localparam int LO = CONV_COUNT - 10;
  localparam int HI = CONV_COUNT - 4;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_busy_up;
    $rose(o_busy);
  endsequence
  sequence s_conv_run;
    o_busy [*8] ##[LO:HI] !o_busy;
  endsequence
  property p_busy_len;
    s_busy_up |-> s_conv_run;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
  property p_busy_cause;
    s_busy_up |-> !i_conversion_start_n && !o_asleep;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_sleep_entry;
    $fell(o_busy) |-> o_asleep == !i_conversion_start_n;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
  property p_sleep_excl;
    $rose(o_asleep) |-> $fell(o_busy);
  endproperty
  a_sleep_excl: assert property (p_sleep_excl) else $error("sleep without conversion end");
  property p_wake;
    $fell(o_asleep) |-> i_conversion_start_n ##1 !o_busy [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("wake interval wrong");
  property p_data_edge;
    $changed(o_serial_result_out) && $past(o_serial_result_oe) |-> !i_sclk;
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved on high clock");
  property p_first_zero;
    $rose(o_serial_result_oe) |-> !o_serial_result_out && i_sclk;
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first bit wrong");
  property p_release;
    $fell(o_serial_result_oe) |-> !i_sclk ##1 !o_serial_result_oe [*4];
  endproperty
  a_release: assert property (p_release) else $error("release wrong");
endmodule : acs_top_monitor
bind acs_top acs_top_monitor #(.W(W), .CONV_COUNT(CONV_COUNT)) acs_top_monitor_inst (
  .i_clk, .i_sys_rst, .i_conversion_start_n, .i_sclk, .o_busy,
  .o_serial_result_out, .o_serial_result_oe, .i_core_code, .o_asleep);
`default_nettype wire

// File: tb/tb_acs_top.sv
// testbench for the conversion and readout block
`timescale 1ns/1ps
`default_nettype none
module tb_acs_top;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [13:0] i_core_code = 14'h0000;
  wire         start_n;
  wire         sclk;
  logic        o_busy;
  logic        o_serial_result_out;
  logic        o_serial_result_oe;
  logic        o_asleep;
  wire         sdo_line;
  logic [15:0] bits;
  logic        ok;
  int          errors = 0;
  int          check_count = 0;
  localparam int CONV_CYCLES = 20;
  always #2 i_clk = ~i_clk;
  // released line shows the inverse of the last bit so a stale bit never matches
  assign sdo_line = o_serial_result_oe ? o_serial_result_out : !o_serial_result_out;
  acs_top #(.WAKE_COUNT(20), .CONV_COUNT(CONV_CYCLES)) acs_top_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_conversion_start_n(start_n),
    .i_sclk(sclk), .o_busy(o_busy), .o_serial_result_out(o_serial_result_out),
    .o_serial_result_oe(o_serial_result_oe), .i_core_code(i_core_code),
    .o_asleep(o_asleep));
  acs_host_model acs_host_model_inst (
    .o_conversion_start_n(start_n), .o_sclk(sclk), .i_busy(o_busy),
    .i_sdo_line(sdo_line));
  task automatic results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic check1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask : check1
  task automatic set_code(input logic [13:0] v);
    @(posedge i_clk) i_core_code <= v;
    #1.3;
  endtask : set_code
  task automatic wb(input logic lvl);
    acs_host_model_inst.wait_busy(lvl, ok);
    check1(ok, 1'b1);
    if (!ok)
      results();
  endtask : wb
  task automatic t_mode1;
    set_code(14'h2a5c);
    acs_host_model_inst.set_start(1'b0, 40);
    acs_host_model_inst.set_start(1'b1, 0);
    wb(1'b1);
    wb(1'b0);
    check1(o_asleep, 1'b0);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h2a5c);
    check1(o_serial_result_oe, 1'b0);
    $display("t_mode1 done");
  endtask : t_mode1
  task automatic t_sleep;
    set_code(14'h3fff);
    acs_host_model_inst.set_start(1'b0, 0);
    wb(1'b1);
    wb(1'b0);
    check1(o_asleep, 1'b1);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h3fff);
    set_code(14'h0001);
    acs_host_model_inst.set_start(1'b1, 40);
    acs_host_model_inst.set_start(1'b0, 20);
    check1(o_busy, 1'b0);
    wb(1'b1);
    wb(1'b0);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h0001);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_long;
    set_code(14'h2000);
    acs_host_model_inst.set_start(1'b1, 6500);
    check1(o_busy, 1'b0);
    acs_host_model_inst.set_start(1'b0, 0);
    wb(1'b1);
    wb(1'b0);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h2000);
    acs_host_model_inst.set_start(1'b1, 2000);
    check1(o_asleep, 1'b0);
    $display("t_long done");
  endtask : t_long
  task automatic t_extra;
    acs_host_model_inst.read_bits(17, bits);
    check(bits, 16'h4000);
    check1(o_serial_result_oe, 1'b1);
    check1(o_serial_result_out, 1'b0);
    acs_host_model_inst.read_bits(15, bits);
    check(bits, 16'h2000);
    check1(o_serial_result_oe, 1'b0);
    $display("t_extra done");
  endtask : t_extra
  task automatic t_resync;
    set_code(14'h1234);
    acs_host_model_inst.read_bits(8, bits);
    check(bits, 16'h0020);
    // start fall with clock low drops the half read
    acs_host_model_inst.set_start(1'b0, 0);
    wb(1'b1);
    wb(1'b0);
    check1(o_asleep, 1'b1);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h1234);
    $display("t_resync done");
  endtask : t_resync
  task automatic t_nobusy;
    set_code(14'h0a5a);
    acs_host_model_inst.set_start(1'b1, 200);
    acs_host_model_inst.set_start(1'b0, 40);
    acs_host_model_inst.set_start(1'b1, 0);
    // read after the conversion time without watching busy
    #((CONV_CYCLES + 25) * 4);
    check1(o_busy, 1'b0);
    check1(o_asleep, 1'b0);
    acs_host_model_inst.set_select(1'b0);
    acs_host_model_inst.read_bits(8, bits);
    check1(o_serial_result_oe, 1'b0);
    acs_host_model_inst.set_select(1'b1);
    acs_host_model_inst.read_bits(16, bits);
    check(bits, 16'h0a5a);
    $display("t_nobusy done");
  endtask : t_nobusy
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #21.3;
    t_mode1();
    t_sleep();
    t_long();
    t_extra();
    t_resync();
    t_nobusy();
    results();
  end
endmodule : tb_acs_top
`default_nettype wire
